// >>> include/lca_pkg.sv
`default_nettype none
package lca_pkg;

  // ------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------
  localparam int CH_NUM = 3;

  // ------------------------------------------------------------
  // Drive monitor, counted in transmit clock periods
  // ------------------------------------------------------------
  localparam int                DMON_W       = 8;
  localparam logic [DMON_W-1:0] DMON_PERIODS = 8'h80;
  localparam logic [DMON_W-1:0] DMON_LAST    = DMON_PERIODS - 8'h01;

  // ------------------------------------------------------------
  // Loss of signal, zero run in receive clock periods
  // ------------------------------------------------------------
  localparam int               LOS_W            = 8;
  localparam logic [LOS_W-1:0] LOS_ZEROS_E3     = 8'h20;
  localparam logic [LOS_W-1:0] LOS_ZEROS_DS3_LO = 8'haf;
  localparam logic [LOS_W-1:0] LOS_ZEROS_DS3_HI = 8'h64;

  // ------------------------------------------------------------
  // Loss of lock, 0.5 percent of a reference window
  // ------------------------------------------------------------
  localparam int                   LOL_CNT_W     = 12;
  localparam int                   LOL_WINDOW_N  = 1024;
  localparam int                   LOL_PER_MILLE = 5;
  localparam logic [LOL_CNT_W-1:0] LOL_WINDOW    = 12'(LOL_WINDOW_N);
  localparam logic [LOL_CNT_W-1:0] LOL_LAST      = 12'(LOL_WINDOW_N - 1);
  localparam logic [LOL_CNT_W-1:0] LOL_TOL       =
    12'(LOL_WINDOW_N * LOL_PER_MILLE / 1000);

  // ------------------------------------------------------------
  // Register map and status layout
  // ------------------------------------------------------------
  localparam int                ADDR_W        = 8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_LCV_BASE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STEP     = 8'h04;
  localparam int                LCV_CNT_W     = 16;
  localparam int                ST_DMON_LSB   = 0;
  localparam int                ST_LOS_LSB    = 4;
  localparam int                ST_LOL_LSB    = 8;
  localparam int                ST_HOST_BIT   = 12;
  localparam logic              RST_OE        = 1'b0;

  // ------------------------------------------------------------
  // Modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LOS_CLEAR    = 2'b01,
    LOS_DECLARED = 2'b10
  } lca_los_e;

  typedef enum logic [3:0] {
    LOOP_NORMAL  = 4'b0001,
    LOOP_ANALOG  = 4'b0010,
    LOOP_REMOTE  = 4'b0100,
    LOOP_DIGITAL = 4'b1000
  } lca_loop_e;

  localparam int LOOP_ANA_BIT = 1;
  localparam int LOOP_REM_BIT = 2;
  localparam int LOOP_DIG_BIT = 3;

endpackage : lca_pkg
`default_nettype wire

// >>> verilog/lca_lol_meter.sv
`timescale 1ns/1ps
`default_nettype none
module lca_lol_meter (
  input  wire logic clock_in,    // 40 MHz clock
  input  wire logic rst_b_in,    // Async reset, active low
  input  wire logic ref_edge_in, // Reference clock rising edge
  input  wire logic rx_edge_in,  // Recovered clock rising edge
  output logic      lol_out      // Loss of lock, registered
);
  import lca_pkg::*;

  // ------------------------------------------------------------
  // Window counters
  // ------------------------------------------------------------
  logic [LOL_CNT_W-1:0] ref_cnt;
  logic [LOL_CNT_W-1:0] next_ref_cnt;
  logic [LOL_CNT_W-1:0] rx_cnt;
  logic [LOL_CNT_W-1:0] next_rx_cnt;
  logic [LOL_CNT_W-1:0] diff;
  logic                 lol;
  logic                 next_lol;
  logic                 win_end;

  always_comb begin
    win_end      = ref_edge_in && (ref_cnt == LOL_LAST);
    next_ref_cnt = ref_cnt;
    next_rx_cnt  = rx_cnt;
    next_lol     = lol;
    diff = (rx_cnt > LOL_WINDOW) ? rx_cnt - LOL_WINDOW
                                 : LOL_WINDOW - rx_cnt;
    if (ref_edge_in) begin
      next_ref_cnt = ref_cnt + 1'b1;
    end
    if (rx_edge_in && rx_cnt != '1) begin
      next_rx_cnt = rx_cnt + 1'b1;
    end
    if (win_end) begin
      next_lol     = diff > LOL_TOL;
      next_ref_cnt = '0;
      next_rx_cnt  = {{(LOL_CNT_W-1){1'b0}}, rx_edge_in};
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_cnt <= '0;
      rx_cnt  <= '0;
      lol     <= 1'b0;
    end else begin
      ref_cnt <= next_ref_cnt;
      rx_cnt  <= next_rx_cnt;
      lol     <= next_lol;
    end
  end

  assign lol_out = lol;

  a_lol_window: assert property (
    @(posedge clock_in) disable iff (!rst_b_in)
    $changed(lol) |-> $past(win_end)
  ) else $error("lock flag moved outside a window end");

endmodule : lca_lol_meter
`default_nettype wire

// >>> verilog/lca_top.sv
// What this block does
// - Drive flag rises after 128 transmit clock periods without monitor pulse
// - Drive flag stays high until a monitor pulse is seen again
// - All-ones select sends alternating AMI marks instead of user data
// - The all-ones marks advance on each transmit clock rising edge
// - All-ones select is ignored in host configuration
// - Loss-of-signal flag is high while a loss is declared
// - E3 and DS3/STS-1 channels use different zero-run criteria
// - Loss-of-lock flag rises when clocks differ by more than 0.5 percent
// - Each code violation gives one single high pulse, low otherwise
// - In-circuit test low releases every line-side output
// - Threshold strap only matters in DS3 or STS-1 mode
// - Local high, remote low selects analog local loop-back
// - Remote high, local low selects remote loop-back
// - Both selects high selects digital local loop-back
// - Host configuration ignores both loop selects
// - Mute enabled forces both receive rails low during loss
// - Mute disabled keeps data flowing; setting only in hardware mode
// - Mode select low is hardware configuration, high is host
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lca_top (
  input  wire logic                       clock_in,  // 40 MHz clock
  input  wire logic                       rst_b_in,  // Async reset, low
  input  wire logic                       psel_in,   // APB select
  input  wire logic                       penable_in, // APB enable
  input  wire logic                       pwrite_in, // APB write
  input  wire logic [lca_pkg::ADDR_W-1:0] paddr_in,  // APB address
  input  wire logic [31:0]                pwdata_in, // APB write data
  output logic      [31:0]                prdata_out, // APB read data
  output logic                            pready_out, // APB ready
  output logic                            pslverr_out, // APB error
  input  wire logic                       config_mode_sel_in, // 1 host
  input  wire logic                       mute_on_los_en_in, // Mute enable
  input  wire logic                       incircuit_test_n_in, // Test, low
  input  wire logic [lca_pkg::CH_NUM-1:0] tx_clock_in,  // Transmit clock
  input  wire logic [lca_pkg::CH_NUM-1:0] tx_pos_in,    // User pos rail
  input  wire logic [lca_pkg::CH_NUM-1:0] tx_neg_in,    // User neg rail
  input  wire logic [lca_pkg::CH_NUM-1:0] monitor_tip_in,  // Monitor tip
  input  wire logic [lca_pkg::CH_NUM-1:0] monitor_ring_in, // Monitor ring
  input  wire logic [lca_pkg::CH_NUM-1:0] all_ones_select_in, // All ones
  input  wire logic [lca_pkg::CH_NUM-1:0] e3_sel_in,    // 1 E3 mode
  input  wire logic [lca_pkg::CH_NUM-1:0] los_threshold_sel_in, // Strap
  input  wire logic [lca_pkg::CH_NUM-1:0] local_loop_sel_in,  // Local
  input  wire logic [lca_pkg::CH_NUM-1:0] remote_loop_sel_in, // Remote
  input  wire logic [lca_pkg::CH_NUM-1:0] rx_clock_in,  // Recovered clock
  input  wire logic [lca_pkg::CH_NUM-1:0] rx_pos_in,    // Recovered pos
  input  wire logic [lca_pkg::CH_NUM-1:0] rx_neg_in,    // Recovered neg
  input  wire logic [lca_pkg::CH_NUM-1:0] ref_clock_in, // Reference clock
  output logic      [lca_pkg::CH_NUM-1:0] tx_pos_out,   // Line pos rail
  output logic      [lca_pkg::CH_NUM-1:0] tx_neg_out,   // Line neg rail
  output logic      [lca_pkg::CH_NUM-1:0] drive_monitor_flag_out, // Drive
  output logic      [lca_pkg::CH_NUM-1:0] loss_signal_flag_out, // LOS
  output logic      [lca_pkg::CH_NUM-1:0] loss_lock_flag_out,   // LOL
  output logic      [lca_pkg::CH_NUM-1:0] code_violation_flag_out, // LCV
  output logic      [lca_pkg::CH_NUM-1:0] rx_pos_rail_out, // Rx pos rail
  output logic      [lca_pkg::CH_NUM-1:0] rx_neg_rail_out, // Rx neg rail
  output logic      [lca_pkg::CH_NUM-1:0] rx_clock_out,    // Rx clock copy
  output logic      [lca_pkg::CH_NUM-1:0] analog_loop_out,  // Analog loop
  output logic      [lca_pkg::CH_NUM-1:0] remote_loop_out,  // Remote loop
  output logic      [lca_pkg::CH_NUM-1:0] digital_loop_out, // Digital loop
  output logic                            outputs_oe_out    // Pin enable
);
  import lca_pkg::*;

  // ------------------------------------------------------------
  // Input edges, strap capture and pin enable
  // ------------------------------------------------------------
  logic [CH_NUM-1:0] tx_prev;
  logic [CH_NUM-1:0] rx_prev;
  logic [CH_NUM-1:0] ref_prev;
  logic [CH_NUM-1:0] strap_val;
  logic [CH_NUM-1:0] next_strap_val;
  logic              strap_taken;
  logic              oe;
  logic [CH_NUM-1:0] tx_edge;
  logic [CH_NUM-1:0] rx_edge;
  logic [CH_NUM-1:0] ref_edge;
  logic [CH_NUM-1:0] mon_pulse;
  logic [CH_NUM-1:0] rx_pulse;
  logic              host;

  always_comb begin
    next_strap_val = strap_taken ? strap_val : los_threshold_sel_in;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_prev     <= '0;
      rx_prev     <= '0;
      ref_prev    <= '0;
      strap_val   <= '0;
      strap_taken <= 1'b0;
      oe          <= RST_OE;
    end else begin
      tx_prev     <= tx_clock_in;
      rx_prev     <= rx_clock_in;
      ref_prev    <= ref_clock_in;
      strap_val   <= next_strap_val;
      strap_taken <= 1'b1;
      oe          <= incircuit_test_n_in;
    end
  end

  assign tx_edge        = tx_clock_in & ~tx_prev;
  assign rx_edge        = rx_clock_in & ~rx_prev;
  assign ref_edge       = ref_clock_in & ~ref_prev;
  assign mon_pulse      = monitor_tip_in ^ monitor_ring_in;
  assign rx_pulse       = rx_pos_in | rx_neg_in;
  assign host           = config_mode_sel_in;
  assign outputs_oe_out = oe;
  assign rx_clock_out   = rx_prev;

  // ------------------------------------------------------------
  // Per-channel transmit, receive and loop-back logic
  // ------------------------------------------------------------
  logic [LCV_CNT_W-1:0] lcv_cnt_all [CH_NUM];
  logic [CH_NUM-1:0]    lcv_clr;

  sequence s_muting(en, lost);
    en && !host && lost;
  endsequence

  for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
    logic [DMON_W-1:0]    dmon_cnt;
    logic [DMON_W-1:0]    next_dmon_cnt;
    logic                 dmon_q;
    logic                 next_dmon_q;
    logic                 ones_on;
    logic                 phase;
    logic                 next_phase;
    logic                 tx_pos_q;
    logic                 next_tx_pos;
    logic                 tx_neg_q;
    logic                 next_tx_neg;
    logic [LOS_W-1:0]     zero_cnt;
    logic [LOS_W-1:0]     next_zero_cnt;
    logic [LOS_W-1:0]     los_thr;
    lca_los_e             los_st;
    lca_los_e             next_los_st;
    logic                 mute;
    logic                 last_pos;
    logic                 next_last_pos;
    logic                 lcv_q;
    logic                 next_lcv;
    logic                 rail_pos;
    logic                 next_rail_pos;
    logic                 rail_neg;
    logic                 next_rail_neg;
    logic [LCV_CNT_W-1:0] lcv_cnt;
    logic [LCV_CNT_W-1:0] next_lcv_cnt;
    lca_loop_e            loop_q;
    lca_loop_e            next_loop;
    logic                 lol_q;

    // Transmit: drive monitor and all-ones insertion
    always_comb begin
      ones_on       = all_ones_select_in[i] && !host;
      next_dmon_cnt = dmon_cnt;
      next_dmon_q   = dmon_q;
      next_phase    = phase;
      next_tx_pos   = tx_pos_q;
      next_tx_neg   = tx_neg_q;
      if (mon_pulse[i]) begin
        next_dmon_cnt = '0;
        next_dmon_q   = 1'b0;
      end else if (tx_edge[i] && dmon_cnt != DMON_PERIODS) begin
        next_dmon_cnt = dmon_cnt + 1'b1;
        if (dmon_cnt == DMON_LAST) begin
          next_dmon_q = 1'b1;
        end
      end
      if (tx_edge[i]) begin
        if (ones_on) begin
          next_phase  = !phase;
          next_tx_pos = !phase;
          next_tx_neg = phase;
        end else begin
          next_tx_pos = tx_pos_in[i];
          next_tx_neg = tx_neg_in[i];
          // Keep track of the last mark so inserted ones still alternate
          if (tx_pos_in[i] != tx_neg_in[i]) begin
            next_phase = tx_pos_in[i];
          end
        end
      end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        dmon_cnt <= '0;
        dmon_q   <= 1'b0;
        phase    <= 1'b0;
        tx_pos_q <= 1'b0;
        tx_neg_q <= 1'b0;
      end else begin
        dmon_cnt <= next_dmon_cnt;
        dmon_q   <= next_dmon_q;
        phase    <= next_phase;
        tx_pos_q <= next_tx_pos;
        tx_neg_q <= next_tx_neg;
      end
    end

    // Receive: loss of signal, violations, rail muting
    always_comb begin
      los_thr = e3_sel_in[i] ? LOS_ZEROS_E3 :
                (strap_val[i] ? LOS_ZEROS_DS3_HI : LOS_ZEROS_DS3_LO);
      next_zero_cnt = zero_cnt;
      next_los_st   = los_st;
      if (rx_edge[i]) begin
        if (rx_pulse[i]) begin
          next_zero_cnt = '0;
        end else if (zero_cnt < los_thr) begin
          next_zero_cnt = zero_cnt + 1'b1;
        end
      end
      case (los_st)
        LOS_CLEAR: begin
          if (next_zero_cnt >= los_thr) begin
            next_los_st = LOS_DECLARED;
          end
        end
        LOS_DECLARED: begin
          if (rx_edge[i] && rx_pulse[i]) begin
            next_los_st = LOS_CLEAR;
          end
        end
        default: next_los_st = LOS_CLEAR;
      endcase
      next_lcv      = 1'b0;
      next_last_pos = last_pos;
      if (rx_edge[i] && rx_pulse[i]) begin
        next_lcv = (rx_pos_in[i] && rx_neg_in[i]) ||
                   (rx_pos_in[i] == last_pos);
        next_last_pos = rx_pos_in[i];
      end
      // Violation pulses are counted; a clear loses no new pulse
      next_lcv_cnt = lcv_clr[i] ? '0 : lcv_cnt;
      if (lcv_q && next_lcv_cnt != '1) begin
        next_lcv_cnt = next_lcv_cnt + 1'b1;
      end
      mute          = mute_on_los_en_in && !host &&
                      los_st == LOS_DECLARED;
      next_rail_pos = rail_pos;
      next_rail_neg = rail_neg;
      if (mute) begin
        next_rail_pos = 1'b0;
        next_rail_neg = 1'b0;
      end else if (rx_edge[i]) begin
        next_rail_pos = rx_pos_in[i];
        next_rail_neg = rx_neg_in[i];
      end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        zero_cnt <= '0;
        los_st   <= LOS_CLEAR;
        lcv_q    <= 1'b0;
        last_pos <= 1'b0;
        lcv_cnt  <= '0;
        rail_pos <= 1'b0;
        rail_neg <= 1'b0;
      end else begin
        zero_cnt <= next_zero_cnt;
        los_st   <= next_los_st;
        lcv_q    <= next_lcv;
        last_pos <= next_last_pos;
        lcv_cnt  <= next_lcv_cnt;
        rail_pos <= next_rail_pos;
        rail_neg <= next_rail_neg;
      end
    end

    // Loop-back decode
    always_comb begin
      next_loop = LOOP_NORMAL;
      if (!host) begin
        case ({local_loop_sel_in[i], remote_loop_sel_in[i]})
          2'b10:   next_loop = LOOP_ANALOG;
          2'b01:   next_loop = LOOP_REMOTE;
          2'b11:   next_loop = LOOP_DIGITAL;
          default: next_loop = LOOP_NORMAL;
        endcase
      end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        loop_q <= LOOP_NORMAL;
      end else begin
        loop_q <= next_loop;
      end
    end

    lca_lol_meter lca_lol_meter_inst (
      .clock_in    (clock_in),
      .rst_b_in    (rst_b_in),
      .ref_edge_in (ref_edge[i]),
      .rx_edge_in  (rx_edge[i]),
      .lol_out     (lol_q)
    );

    assign tx_pos_out[i]              = tx_pos_q;
    assign tx_neg_out[i]              = tx_neg_q;
    assign drive_monitor_flag_out[i]  = dmon_q;
    assign loss_signal_flag_out[i]    = los_st[1];
    assign loss_lock_flag_out[i]      = lol_q;
    assign code_violation_flag_out[i] = lcv_q;
    assign rx_pos_rail_out[i]         = rail_pos;
    assign rx_neg_rail_out[i]         = rail_neg;
    assign analog_loop_out[i]         = loop_q[LOOP_ANA_BIT];
    assign remote_loop_out[i]         = loop_q[LOOP_REM_BIT];
    assign digital_loop_out[i]        = loop_q[LOOP_DIG_BIT];
    assign lcv_cnt_all[i]             = lcv_cnt;

    a_dmon_raise_count: assert property (
      @(posedge clock_in) disable iff (!rst_b_in)
      $rose(dmon_q) |-> $past(dmon_cnt) == DMON_LAST && $past(tx_edge[i])
    ) else $error("drive flag rose at wrong period count");

    a_dmon_clear_pulse: assert property (
      @(posedge clock_in) disable iff (!rst_b_in)
      $fell(dmon_q) |-> $past(mon_pulse[i])
    ) else $error("drive flag fell without monitor pulse");

    a_ones_alternate: assert property (
      @(posedge clock_in) disable iff (!rst_b_in)
      tx_edge[i] && ones_on |=> tx_pos_q != tx_neg_q &&
        ($past(tx_pos_q) == $past(tx_neg_q) ||
         tx_pos_q != $past(tx_pos_q))
    ) else $error("all-ones marks did not alternate");

    a_ones_host_off: assert property (
      @(posedge clock_in) disable iff (!rst_b_in)
      tx_edge[i] && host |=> tx_pos_q == $past(tx_pos_in[i])
    ) else $error("all-ones active in host configuration");

    a_los_e3_run: assert property (
      @(posedge clock_in) disable iff (!rst_b_in)
      $rose(los_st[1]) && $past(e3_sel_in[i]) |->
        $past(zero_cnt) + 8'h01 == LOS_ZEROS_E3
    ) else $error("E3 loss declared at wrong zero run");

    a_lcv_single: assert property (
      @(posedge clock_in) disable iff (!rst_b_in)
      lcv_q |=> !lcv_q
    ) else $error("violation pulse longer than one cycle");

    a_ict_release: assert property (
      @(posedge clock_in) disable iff (!rst_b_in)
      !incircuit_test_n_in |=> !outputs_oe_out
    ) else $error("outputs still enabled under test");

    a_loop_digital: assert property (
      @(posedge clock_in) disable iff (!rst_b_in)
      local_loop_sel_in[i] && remote_loop_sel_in[i] && !host
        |=> digital_loop_out[i] && !analog_loop_out[i]
    ) else $error("digital loop-back not selected");

    a_loop_host: assert property (
      @(posedge clock_in) disable iff (!rst_b_in)
      host |=> loop_q == LOOP_NORMAL
    ) else $error("loop selects honoured in host configuration");

    a_mute_rails: assert property (
      @(posedge clock_in) disable iff (!rst_b_in)
      s_muting(mute_on_los_en_in, los_st[1])
        |=> !rx_pos_rail_out[i] && !rx_neg_rail_out[i]
    ) else $error("rails not muted during loss");
  end

  // ------------------------------------------------------------
  // APB register slave
  // ------------------------------------------------------------
  logic [31:0] prdata_q;
  logic [31:0] next_prdata;
  logic [31:0] status;
  logic [31:0] rd;
  logic        pready_q;
  logic        next_pready;
  logic        pslverr_q;
  logic        next_pslverr;
  logic        hit;
  logic        acc_wr;

  always_comb begin
    acc_wr       = psel_in && penable_in && pready_q && pwrite_in;
    next_pready  = psel_in && !penable_in;
    next_prdata  = prdata_q;
    next_pslverr = 1'b0;
    status       = '0;
    status[ST_DMON_LSB +: CH_NUM] = drive_monitor_flag_out;
    status[ST_LOS_LSB +: CH_NUM]  = loss_signal_flag_out;
    status[ST_LOL_LSB +: CH_NUM]  = loss_lock_flag_out;
    status[ST_HOST_BIT]           = host;
    hit     = (paddr_in == ADDR_STATUS);
    rd      = hit ? status : '0;
    lcv_clr = '0;
    for (int k = 0; k < CH_NUM; k++) begin
      if (paddr_in == ADDR_LCV_BASE + 8'(k) * ADDR_STEP) begin
        hit        = 1'b1;
        rd         = 32'(lcv_cnt_all[k]);
        lcv_clr[k] = acc_wr;
      end
    end
    if (next_pready) begin
      next_prdata  = pwrite_in ? '0 : rd;
      next_pslverr = !hit;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= next_prdata;
      pready_q  <= next_pready;
      pslverr_q <= next_pslverr;
    end
  end

  assign prdata_out  = prdata_q;
  assign pready_out  = pready_q;
  assign pslverr_out = pslverr_q;

endmodule : lca_top
`default_nettype wire

// >>> sim/lca_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Framer side: line clocks and AMI marks, one mark each period
// ------------------------------------------------------------
module lca_far_model (
  input  wire logic clock_in, // System clock
  input  wire logic rst_b_in, // Reset, active low
  input  wire logic live_in,  // Send marks
  input  wire logic bad_in,   // Repeat mark polarity once
  output logic      lclk_out, // Line clock, a quarter rate
  output logic      pos_out,  // Positive mark
  output logic      neg_out   // Negative mark
);
  logic [1:0] cnt;
  logic       ph;
  assign lclk_out = cnt[1];
  // Marks change while the line clock is low, stable at its rise
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt     <= 2'h0;
      ph      <= 1'b0;
      pos_out <= 1'b0;
      neg_out <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h0) begin
        pos_out <= live_in & ~ph;
        neg_out <= live_in & ph;
        ph      <= ph ^ (live_in & ~bad_in);
      end
    end
  end
endmodule : lca_far_model
`default_nettype wire

// >>> sim/lca_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module lca_top_tb;
  import lca_pkg::*;
  logic        clock_in;
  logic        rst_b_in = 1'b0;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic        host = 1'b0, mute = 1'b1, ict_n = 1'b1;
  logic        live = 1'b1, bad = 1'b0, lc, mp, mn, err, oe, p, lcs;
  logic        rc = 1'b0, slow = 1'b0;
  logic [1:0]  rn = 2'h0;
  logic [2:0]  lsel = 3'h0, rsel = 3'h0, aos = 3'h0;
  logic [2:0]  txp, txn, dmo, los, lol, lcv, ana, rem, dig, rxp, rxn, rck;
  logic [31:0] rd, prdata;
  logic        pready, pslverr;
  int          n_fail = 0, n_checks = 0, k, nv;

  lca_far_model lca_far_model_inst (.clock_in, .rst_b_in, .live_in(live),
    .bad_in(bad), .lclk_out(lc), .pos_out(mp), .neg_out(mn));

  lca_top lca_top_inst (.clock_in, .rst_b_in, .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(32'h0),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .config_mode_sel_in(host), .mute_on_los_en_in(mute),
    .incircuit_test_n_in(ict_n), .tx_clock_in({3{lc}}),
    .tx_pos_in(3'h0), .tx_neg_in(3'h0), .monitor_tip_in({3{mp}}),
    .monitor_ring_in({3{mn}}), .all_ones_select_in(aos),
    .e3_sel_in(3'h1), .los_threshold_sel_in(3'h2),
    .local_loop_sel_in(lsel), .remote_loop_sel_in(rsel),
    .rx_clock_in({3{lc}}), .rx_pos_in({3{mp}}), .rx_neg_in({3{mn}}),
    .ref_clock_in({3{slow ? rc : lc}}), .tx_pos_out(txp), .tx_neg_out(txn),
    .drive_monitor_flag_out(dmo), .loss_signal_flag_out(los),
    .loss_lock_flag_out(lol), .code_violation_flag_out(lcv),
    .rx_pos_rail_out(rxp), .rx_neg_rail_out(rxn), .rx_clock_out(rck),
    .analog_loop_out(ana), .remote_loop_out(rem), .digital_loop_out(dig),
    .outputs_oe_out(oe));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // Slow reference, a period of six cycles, for the lock test
  always @(posedge clock_in) begin
    rn <= (rn == 2'h2) ? 2'h0 : rn + 2'h1;
    rc <= rc ^ (rn == 2'h2);
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a);
    @(posedge clock_in);
    psel  <= 1'b1;
    pwr   <= w;
    paddr <= a;
    @(posedge clock_in);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    rd   = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  // Bounded wait for loss of signal (sel 0) or loss of lock (sel 1)
  task automatic wait_flag(input logic sel, input logic [2:0] v,
                           input int n);
    k = 0;
    while ((sel ? lol : los) !== v && k < n) begin
      @(posedge clock_in);
      k++;
    end
    `CHK(sel ? lol : los, v)
    if ((sel ? lol : los) !== v) end_sim();
  endtask : wait_flag
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    tick(8);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      lsel <= {3{i[0]}};
      rsel <= {3{i[1]}};
      tick(3);
      `CHK({dig, rem, ana}, i == 0 ? 9'h0 : 9'h7 << (3 * (i - 1)))
    end
    host <= 1'b1;
    tick(3);
    `CHK({dig, rem, ana}, 9'h0)
    host <= 1'b0;
    $display("test loop done");
    aos <= 3'h7;
    tick(8);
    for (int i = 0; i < 8; i++) begin
      tick(4);
      `CHK(txp ^ txn, 3'h7)
      if (i > 0) `CHK(txp, ~{3{p}})
      p = txp[0];
    end
    host <= 1'b1;
    tick(12);
    `CHK(txp | txn, 3'h0)
    host <= 1'b0;
    aos  <= 3'h0;
    ict_n <= 1'b0;
    tick(3);
    `CHK(oe, 1'b0)
    ict_n <= 1'b1;
    tick(3);
    `CHK(oe, 1'b1)
    $display("test transmit done");
    apb(1'b1, 8'h04);
    bad <= 1'b1;
    tick(4);
    bad <= 1'b0;
    nv = 0;
    repeat (40) begin
      lcs = lc;
      @(posedge clock_in);
      nv += lcv[0];
      `CHK(rck, {3{lcs}})
    end
    `CHK(nv, 1)
    apb(1'b0, 8'h04);
    `CHK(rd, 32'h1)
    apb(1'b1, 8'h04);
    apb(1'b0, 8'h04);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h40);
    `CHK({err, rd}, 33'h1_0000_0000)
    $display("test violation done");
    live <= 1'b0;
    tick(360);
    `CHK({dmo, los}, 6'h01)
    tick(100);
    `CHK(los, 3'h3)
    tick(200);
    `CHK(dmo, 3'h7)
    tick(100);
    `CHK(los, 3'h7)
    apb(1'b0, 8'h00);
    `CHK(rd, 32'h77)
    live <= 1'b1;
    wait_flag(1'b0, 3'h0, 40);
    `CHK(rxp | rxn, 3'h0)
    tick(40);
    `CHK({dmo, los, lol}, 9'h0)
    mute <= 1'b0;
    live <= 1'b0;
    tick(200);
    `CHK(los, 3'h1)
    live <= 1'b1;
    wait_flag(1'b0, 3'h0, 40);
    `CHK(rxp ^ rxn, 3'h7)
    $display("test alarm done");
    slow <= 1'b1;
    wait_flag(1'b1, 3'h7, 20000);
    slow <= 1'b0;
    wait_flag(1'b1, 3'h0, 20000);
    $display("test lock done");
    end_sim();
  end
endmodule : lca_top_tb
`default_nettype wire
